/* File: core/rtcrs_override_detect.sv */
// detector for the reset-override pin sequence on sda_ce and scl
`timescale 1ns/100ps
module rtcrs_override_detect import rtcrs_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic sda_ce_pin,
	input wire logic scl_pin,
	output logic enter
);
	logic [1:0] sda_sync_reg, sda_sync_next;
	logic [1:0] scl_sync_reg, scl_sync_next;
	logic sda_last_reg, sda_last_next;
	logic scl_last_reg, scl_last_next;
	logic [3:0] edge_cnt_reg, edge_cnt_next;
	logic enter_reg, enter_next;
	rtcrs_ov_state_type state_reg, state_next;
	logic scl_rise;
	logic sda_rise;
	logic sda_fall;

	// pin synchronisers and edge detection on the second stage only
	always_comb begin
		sda_sync_next = {sda_sync_reg[0], sda_ce_pin};
		scl_sync_next = {scl_sync_reg[0], scl_pin};
		sda_last_next = sda_sync_reg[1];
		scl_last_next = scl_sync_reg[1];
		scl_rise = scl_sync_reg[1] & ~scl_last_reg;
		sda_rise = sda_sync_reg[1] & ~sda_last_reg;
		sda_fall = ~sda_sync_reg[1] & sda_last_reg;
	end

	// sequence: sda_ce falls, scl toggles, sda_ce rises again
	always_comb begin
		state_next = state_reg;
		edge_cnt_next = edge_cnt_reg;
		enter_next = 1'b0;
		unique case (state_reg)
			OV_IDLE: begin
				edge_cnt_next = 4'h0;
				if (enable) begin
					state_next = OV_ARMED;
				end
			end
			OV_ARMED: begin
				if (sda_fall) begin
					state_next = OV_COUNT;
				end
			end
			OV_COUNT: begin
				// saturate so a long scl burst cannot wrap back below the minimum
				if (scl_rise && edge_cnt_reg != 4'hF) begin
					edge_cnt_next = edge_cnt_reg + 4'h1;
				end
				if (sda_rise) begin
					state_next = (int'(edge_cnt_reg) >= OVRD_SCL_EDGES) ? OV_WAIT_RISE : OV_ARMED;
					edge_cnt_next = 4'h0;
				end
			end
			OV_WAIT_RISE: begin
				enter_next = 1'b1;
				state_next = OV_IDLE;
			end
		endcase
		if (!enable) begin
			state_next = OV_IDLE;
			enter_next = 1'b0;
		end
	end

	// registers
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sda_sync_reg <= 2'h3;
			scl_sync_reg <= 2'h3;
			sda_last_reg <= 1'b1;
			scl_last_reg <= 1'b1;
			edge_cnt_reg <= 4'h0;
			enter_reg <= 1'b0;
			state_reg <= OV_IDLE;
		end else begin
			sda_sync_reg <= sda_sync_next;
			scl_sync_reg <= scl_sync_next;
			sda_last_reg <= sda_last_next;
			scl_last_reg <= scl_last_next;
			edge_cnt_reg <= edge_cnt_next;
			enter_reg <= enter_next;
			state_reg <= state_next;
		end
	end

	assign enter = enter_reg;
endmodule

/* File: core/rtcrs_pkg.sv */
// shared constants and types of the rtc reset and oscillator-stop controller
package rtcrs_pkg;
	// register offsets
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] RESET_CMD_ADDR = 8'h05;
	localparam logic [7:0] HUNDREDTHS_ADDR = 8'h06;
	localparam logic [7:0] SECONDS_ADDR = 8'h07;
	localparam logic [7:0] TS_FIRST_ADDR = 8'h14;
	localparam logic [7:0] TS_LAST_ADDR = 8'h2F;
	localparam int TS_COUNT = 28;
	// reset command codes and read-back pattern
	localparam logic [7:0] CMD_SOFT_RESET = 8'h2C;
	localparam logic [7:0] CMD_PRESCALER_CLEAR = 8'hA4;
	localparam logic [7:0] CMD_TS_CLEAR = 8'h25;
	localparam logic [7:0] CMD_BOTH_CLEAR = 8'hA5;
	localparam logic [7:0] RESET_CMD_READBACK = 8'h24;
	// control register fields
	localparam int CTRL_HUND_EN_BIT = 0;
	localparam int CTRL_12H_BIT = 1;
	localparam int CTRL_CLOCK_OUTPUT_PIN_OFF_BIT = 2;
	localparam int CTRL_OVRD_EN_BIT = 3;
	localparam int CTRL_TRIM_REFRESH_BIT = 4;
	localparam int CTRL_STOP_BIT = 5;
	localparam int CTRL_BATT_EN_BIT = 6;
	localparam int CTRL_TCOMP_OFF_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h01;
	// seconds register fields and reset values
	localparam int OSF_BIT = 7;
	localparam logic [7:0] HUNDREDTHS_RESET = 8'h00;
	localparam logic [6:0] SECONDS_RESET = 7'h00;
	localparam logic [7:0] BCD_MAX_HUND = 8'h99;
	localparam logic [6:0] BCD_MAX_SEC = 7'h59;
	// timing: one hundredth of a second at the 10 MHz reference
	localparam int CLK_PERIOD_NS = 100;
	localparam int HUNDREDTH_NS = 10000000;
	localparam int HUNDREDTH_CYCLES = HUNDREDTH_NS / CLK_PERIOD_NS;
	// override entry: scl rising edges counted while sda_ce is low
	localparam int OVRD_SCL_EDGES = 2;
	// register request from the bus interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rtcrs_req_type;
	// supply and oscillator monitor levels
	typedef struct packed {
		logic osc_running;
		logic osc_supply_ok;
		logic vdd_low;
	} rtcrs_mon_type;
	// override sequence detector states
	typedef enum logic [1:0] {
		OV_IDLE = 2'b00,
		OV_ARMED = 2'b01,
		OV_COUNT = 2'b10,
		OV_WAIT_RISE = 2'b11
	} rtcrs_ov_state_type;
endpackage

/* File: core/rtcrs_top.sv */
// rtc reset control: oscillator-stop flag, power-on reset, override, reset commands, hundredths
`timescale 1ns/100ps
module rtcrs_top import rtcrs_pkg::*; #(
	parameter int TICK_CYCLES = HUNDREDTH_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire rtcrs_req_type req,
	input wire rtcrs_mon_type mon_pins,
	input wire logic sda_ce_pin,
	input wire logic scl_pin,
	output logic [7:0] rdata,
	output logic internal_reset,
	output logic reset_override_mode,
	output logic defaults_load,
	output logic prescaler_clear_cmd,
	output logic timestamp_clear,
	output logic minute_carry,
	output logic clock_output_pin_en,
	output logic twelve_hour_mode,
	output logic battery_switch_en,
	output logic temp_comp_en
);
	logic [1:0] mon_s1_reg, mon_s1_next;
	logic [1:0] mon_s2_reg, mon_s2_next;
	logic [1:0] vlow_sync_reg, vlow_sync_next;
	logic fault_reg, fault_next;
	logic osc_stop_flag_reg, osc_stop_flag_next;
	logic ovrd_mode_reg, ovrd_mode_next;
	logic por_reg, por_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] hund_reg, hund_next;
	logic [6:0] sec_reg, sec_next;
	logic [16:0] presc_reg, presc_next;
	logic [7:0] rdata_reg, rdata_next;
	logic dload_reg, dload_next;
	logic cpr_reg, cpr_next;
	logic cts_reg, cts_next;
	logic mcarry_reg, mcarry_next;
	logic clock_output_pin_en_reg, clock_output_pin_en_next;
	logic tcomp_en_reg, tcomp_en_next;
	logic [7:0] ts_reg [TS_COUNT];
	logic ovrd_enter;
	logic supply_bad;
	logic cmd_wr;
	logic do_soft;
	logic do_cpr;
	logic do_cts;
	logic tick;
	logic run;

	rtcrs_override_detect u_ovrd (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.enable(ctrl_reg[CTRL_OVRD_EN_BIT]),
		.sda_ce_pin(sda_ce_pin),
		.scl_pin(scl_pin),
		.enter(ovrd_enter)
	);

	// monitor synchronisers; the first stage feeds only the second
	always_comb begin
		mon_s1_next = {mon_pins.osc_running, mon_pins.osc_supply_ok};
		mon_s2_next = mon_s1_reg;
		vlow_sync_next = {vlow_sync_reg[0], mon_pins.vdd_low};
	end

	assign supply_bad = ~mon_s2_reg[0] | vlow_sync_reg[1];

	// reset command decode; unknown values do nothing
	always_comb begin
		cmd_wr = req.wr && (req.addr == RESET_CMD_ADDR);
		do_soft = cmd_wr && (req.wdata == CMD_SOFT_RESET);
		do_cpr = do_soft || (cmd_wr && (req.wdata == CMD_PRESCALER_CLEAR || req.wdata == CMD_BOTH_CLEAR));
		do_cts = do_soft || (cmd_wr && (req.wdata == CMD_TS_CLEAR || req.wdata == CMD_BOTH_CLEAR));
	end

	// power-on reset, flag and override mode
	always_comb begin
		fault_next = supply_bad;
		por_next = supply_bad | ~mon_s2_reg[1];
		ovrd_mode_next = ovrd_mode_reg;
		if (ovrd_enter) begin
			ovrd_mode_next = 1'b1;
		end
		if (!ctrl_reg[CTRL_OVRD_EN_BIT]) begin
			ovrd_mode_next = 1'b0;
		end
		if (ovrd_mode_next) begin
			por_next = 1'b0;
		end
		osc_stop_flag_next = osc_stop_flag_reg;
		if (req.wr && req.addr == SECONDS_ADDR && !req.wdata[OSF_BIT]) begin
			osc_stop_flag_next = 1'b0;
		end
		// fault sets flag, wins over clear
		// any internal reset sets it too
		if (supply_bad || fault_reg || por_reg) begin
			osc_stop_flag_next = 1'b1;
		end
	end

	// control register with defaults on power-on and soft reset
	always_comb begin
		ctrl_next = ctrl_reg;
		if (req.wr && req.addr == CTRL_ADDR) begin
			ctrl_next = req.wdata;
		end
		// power-on defaults, override enable still writable
		if (por_reg) begin
			ctrl_next = CTRL_RESET;
			ctrl_next[CTRL_OVRD_EN_BIT] = (req.wr && req.addr == CTRL_ADDR) ?
				req.wdata[CTRL_OVRD_EN_BIT] : ctrl_reg[CTRL_OVRD_EN_BIT];
		end
		// soft reset keeps override and trim bits
		if (do_soft) begin
			ctrl_next = CTRL_RESET;
			ctrl_next[CTRL_OVRD_EN_BIT] = ctrl_reg[CTRL_OVRD_EN_BIT];
			ctrl_next[CTRL_TRIM_REFRESH_BIT] = ctrl_reg[CTRL_TRIM_REFRESH_BIT];
		end
	end

	// prescaler, hundredths and seconds counting
	always_comb begin
		run = ~por_reg & ~ctrl_reg[CTRL_STOP_BIT];
		tick = run && (presc_reg == 17'(TICK_CYCLES - 1));
		presc_next = run ? (tick ? 17'h0_0000 : presc_reg + 17'h0_0001) : presc_reg;
		hund_next = hund_reg;
		sec_next = sec_reg;
		mcarry_next = 1'b0;
		if (tick) begin
			if (!ctrl_reg[CTRL_HUND_EN_BIT] || hund_reg == BCD_MAX_HUND) begin
				hund_next = HUNDREDTHS_RESET;
				if (sec_reg == BCD_MAX_SEC) begin
					sec_next = SECONDS_RESET;
					mcarry_next = 1'b1;
				end else if (sec_reg[3:0] == 4'h9) begin
					sec_next = {sec_reg[6:4] + 3'h1, 4'h0};
				end else begin
					sec_next = sec_reg + 7'h01;
				end
			end else if (hund_reg[3:0] == 4'h9) begin
				hund_next = {hund_reg[7:4] + 4'h1, 4'h0};
			end else begin
				hund_next = hund_reg + 8'h01;
			end
		end
		if (req.wr && req.addr == HUNDREDTHS_ADDR) begin
			hund_next = req.wdata;
		end
		if (req.wr && req.addr == SECONDS_ADDR) begin
			sec_next = req.wdata[6:0];
		end
		if (do_cpr) begin
			presc_next = 17'h0_0000;
		end
		// time zero on power-on and soft reset
		if (por_reg || do_soft) begin
			hund_next = HUNDREDTHS_RESET;
			sec_next = SECONDS_RESET;
			presc_next = 17'h0_0000;
		end
	end

	// read data and one-cycle command pulses
	always_comb begin
		rdata_next = rdata_reg;
		if (req.rd) begin
			rdata_next = 8'h00;
			if (req.addr == CTRL_ADDR) begin
				rdata_next = ctrl_reg;
			end
			if (req.addr == RESET_CMD_ADDR) begin
				rdata_next = RESET_CMD_READBACK;
			end
			if (req.addr == HUNDREDTHS_ADDR) begin
				rdata_next = hund_reg;
			end
			if (req.addr == SECONDS_ADDR) begin
				rdata_next = {osc_stop_flag_reg, sec_reg};
			end
			if (req.addr >= TS_FIRST_ADDR && req.addr <= TS_LAST_ADDR) begin
				rdata_next = ts_reg[5'(req.addr - TS_FIRST_ADDR)];
			end
		end
		dload_next = do_soft | (por_reg & ~por_next);
		cpr_next = do_cpr;
		cts_next = do_cts;
		// active-high enables kept in their own flops so the pins need no inverter
		clock_output_pin_en_next = ~ctrl_next[CTRL_CLOCK_OUTPUT_PIN_OFF_BIT];
		tcomp_en_next = ~ctrl_next[CTRL_TCOMP_OFF_BIT];
	end

	// timestamp storage, one entry per address
	genvar i;
	generate
		for (i = 0; i < TS_COUNT; i++) begin : g_ts
			logic [7:0] ts_next;
			always_comb begin
				ts_next = ts_reg[i];
				if (req.wr && req.addr == TS_FIRST_ADDR + 8'(i)) begin
					ts_next = req.wdata;
				end
				if (do_cts) begin
					ts_next = 8'h00;
				end
			end
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					ts_reg[i] <= 8'h00;
				end else begin
					ts_reg[i] <= ts_next;
				end
			end
		end
	endgenerate

	// state registers
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			mon_s1_reg <= 2'h0;
			mon_s2_reg <= 2'h0;
			vlow_sync_reg <= 2'h0;
			fault_reg <= 1'b0;
			osc_stop_flag_reg <= 1'b1;
			ovrd_mode_reg <= 1'b0;
			por_reg <= 1'b1;
			ctrl_reg <= CTRL_RESET;
			hund_reg <= HUNDREDTHS_RESET;
			sec_reg <= SECONDS_RESET;
			presc_reg <= 17'h0_0000;
			rdata_reg <= 8'h00;
			dload_reg <= 1'b0;
			cpr_reg <= 1'b0;
			cts_reg <= 1'b0;
			mcarry_reg <= 1'b0;
			clock_output_pin_en_reg <= ~CTRL_RESET[CTRL_CLOCK_OUTPUT_PIN_OFF_BIT];
			tcomp_en_reg <= ~CTRL_RESET[CTRL_TCOMP_OFF_BIT];
		end else begin
			mon_s1_reg <= mon_s1_next;
			mon_s2_reg <= mon_s2_next;
			vlow_sync_reg <= vlow_sync_next;
			fault_reg <= fault_next;
			osc_stop_flag_reg <= osc_stop_flag_next;
			ovrd_mode_reg <= ovrd_mode_next;
			por_reg <= por_next;
			ctrl_reg <= ctrl_next;
			hund_reg <= hund_next;
			sec_reg <= sec_next;
			presc_reg <= presc_next;
			rdata_reg <= rdata_next;
			dload_reg <= dload_next;
			cpr_reg <= cpr_next;
			cts_reg <= cts_next;
			mcarry_reg <= mcarry_next;
			clock_output_pin_en_reg <= clock_output_pin_en_next;
			tcomp_en_reg <= tcomp_en_next;
		end
	end

	// outputs straight from flip-flops
	assign rdata = rdata_reg;
	assign internal_reset = por_reg;
	assign reset_override_mode = ovrd_mode_reg;
	assign defaults_load = dload_reg;
	assign prescaler_clear_cmd = cpr_reg;
	assign timestamp_clear = cts_reg;
	assign minute_carry = mcarry_reg;
	assign clock_output_pin_en = clock_output_pin_en_reg;
	assign twelve_hour_mode = ctrl_reg[CTRL_12H_BIT];
	assign battery_switch_en = ctrl_reg[CTRL_BATT_EN_BIT];
	assign temp_comp_en = tcomp_en_reg;
endmodule

/* File: verification/rtcrs_chk.sv */
// port assertions of the rtc reset controller
`timescale 1ns/100ps
module rtcrs_chk import rtcrs_pkg::*; (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire rtcrs_req_type req,
	input wire rtcrs_mon_type mon_pins,
	input wire logic [7:0] rdata,
	input wire logic internal_reset,
	input wire logic reset_override_mode,
	input wire logic defaults_load,
	input wire logic prescaler_clear_cmd,
	input wire logic timestamp_clear,
	input wire logic clock_output_pin_en,
	input wire logic twelve_hour_mode,
	input wire logic battery_switch_en,
	input wire logic temp_comp_en
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic cw;
	// write to the reset command register
	assign cw = req.wr && req.addr == RESET_CMD_ADDR;
	AST_SOFT_RESET: assert property (cw && req.wdata == CMD_SOFT_RESET |=>
		defaults_load && prescaler_clear_cmd && timestamp_clear) else $error("soft reset pulses missing");
	AST_CLR_PRESC: assert property (cw && req.wdata == CMD_PRESCALER_CLEAR |=>
		prescaler_clear_cmd && !timestamp_clear) else $error("prescaler clear wrong");
	AST_CLR_BOTH: assert property (cw && req.wdata == CMD_BOTH_CLEAR |=>
		prescaler_clear_cmd && timestamp_clear) else $error("combined clear wrong");
	AST_READBACK: assert property (req.rd && req.addr == RESET_CMD_ADDR |=>
		rdata == RESET_CMD_READBACK) else $error("command readback wrong");
	AST_IGNORED: assert property (timestamp_clear |-> $past(cw && (req.wdata == CMD_SOFT_RESET
		|| req.wdata == CMD_TS_CLEAR || req.wdata == CMD_BOTH_CLEAR))) else $error("clear without code");
	AST_FAULT: assert property ((!mon_pins.osc_supply_ok || mon_pins.vdd_low) [*4] |->
		internal_reset || reset_override_mode) else $error("fault did not reset");
	AST_OVRD_REL: assert property (reset_override_mode |-> !internal_reset)
		else $error("override kept reset");
	AST_OVRD_EXIT: assert property (req.wr && req.addr == CTRL_ADDR && !req.wdata[CTRL_OVRD_EN_BIT] |->
		##[1:2] !reset_override_mode) else $error("override not left");
	AST_DEFAULTS: assert property (defaults_load |-> clock_output_pin_en && temp_comp_en
		&& !twelve_hour_mode && !battery_switch_en) else $error("defaults wrong");
	// main scenarios reached
	C_OVRD: cover property (reset_override_mode);
	C_SOFT: cover property (defaults_load && timestamp_clear);
	C_REL: cover property ($fell(internal_reset));
endmodule

/* File: verification/rtcrs_host.sv */
// host model: register requests and override pin toggling
`timescale 1ns/100ps
module rtcrs_host import rtcrs_pkg::*; (
	input wire logic ref_clk,
	output rtcrs_req_type req,
	output logic sda_ce_pin,
	output logic scl_pin
);
	// bus idle, pins pulled high
	initial begin
		req = '0;
		sda_ce_pin = 1'b1;
		scl_pin = 1'b1;
	end
	// one-cycle register access
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge ref_clk);
		req <= '0;
	endtask
	task automatic clr_prescaler();
		acc(1'b1, CTRL_ADDR, 8'h21);
		acc(1'b1, RESET_CMD_ADDR, CMD_PRESCALER_CLEAR);
	endtask
	task automatic trim_refresh();
		acc(1'b1, CTRL_ADDR, 8'h31);
	endtask
	task automatic enter_override();
		int i;
		acc(1'b1, CTRL_ADDR, 8'h09);
		repeat (4) @(posedge ref_clk);
		sda_ce_pin <= 1'b0;
		for (i = 0; i < 4; i++) begin
			repeat (4) @(posedge ref_clk);
			scl_pin <= ~scl_pin;
		end
		repeat (4) @(posedge ref_clk);
		sda_ce_pin <= 1'b1;
	endtask
endmodule

/* File: verification/rtcrs_top_tb.sv */
// testbench of the rtc reset controller
`timescale 1ns/100ps
module rtcrs_top_tb import rtcrs_pkg::*;;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	rtcrs_mon_type mon_pins = '{1'b0, 1'b1, 1'b0};
	rtcrs_req_type req;
	logic sda_ce_pin, scl_pin, internal_reset, reset_override_mode, defaults_load, prescaler_clear_cmd;
	logic timestamp_clear, minute_carry, clock_output_pin_en, twelve_hour_mode, battery_switch_en, temp_comp_en;
	logic [7:0] rdata, v, a;
	logic p1 = 1'b0;
	logic p2 = 1'b0;
	logic [7:0] rq[$];
	logic [2:0] pq[$];
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int i, k;
	rtcrs_top #(.TICK_CYCLES(10)) u_dut (.ref_clk, .rstn, .req, .mon_pins, .sda_ce_pin, .scl_pin, .rdata,
		.internal_reset, .reset_override_mode, .defaults_load, .prescaler_clear_cmd, .timestamp_clear,
		.minute_carry, .clock_output_pin_en, .twelve_hour_mode, .battery_switch_en, .temp_comp_en);
	rtcrs_host u_host (.ref_clk, .req, .sda_ce_pin, .scl_pin);
	// clock
	initial forever #50 ref_clk = ~ref_clk;
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t read %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t flags %b not %b", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		rq.push_back(e);
		u_host.acc(1'b0, ad, 8'h00);
	endtask
	task automatic cmd(input logic [7:0] d, input logic [2:0] e);
		if (e != 3'b000)
			pq.push_back(e);
		u_host.acc(1'b1, RESET_CMD_ADDR, d);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// read pipeline tracking and hang guard
	always @(posedge ref_clk) begin
		p1 <= req.rd;
		p2 <= p1;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			wrap_up();
		end
	end
	// results matched to the oldest note
	always @(negedge ref_clk) begin
		if (p2)
			chk_rd(rdata, rq.pop_front());
		if (prescaler_clear_cmd || timestamp_clear)
			chk_bits({defaults_load, prescaler_clear_cmd, timestamp_clear}, pq.size() ? pq.pop_front() : 3'b000);
	end
	// main sequence
	initial begin
		void'($urandom(42829));
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(HUNDREDTHS_ADDR, HUNDREDTHS_RESET);
		rd(SECONDS_ADDR, 8'h80);
		chk_bits({2'b00, internal_reset}, 3'b001);
		mon_pins.osc_running <= 1'b1;
		for (k = 0; k < 40 && internal_reset !== 1'b0; k++) @(negedge ref_clk);
		chk_bits({2'b00, internal_reset}, 3'b000);
		u_host.acc(1'b1, CTRL_ADDR, 8'h21);
		rd(SECONDS_ADDR, 8'h80);
		u_host.acc(1'b1, SECONDS_ADDR, 8'h00);
		u_host.trim_refresh();
		rd(SECONDS_ADDR, 8'h00);
		for (i = 0; i < 2; i++) begin
			u_host.acc(1'b1, SECONDS_ADDR, 8'h00);
			mon_pins <= '{1'b1, i[0], i[0]};
			repeat (6) @(posedge ref_clk);
			chk_bits({2'b00, internal_reset}, 3'b001);
			mon_pins <= '{1'b1, 1'b1, 1'b0};
			for (k = 0; k < 40 && internal_reset !== 1'b0; k++) @(negedge ref_clk);
			rd(SECONDS_ADDR, 8'h80);
		end
		$display("test flag done");
		pq.push_back(3'b010);
		u_host.clr_prescaler();
		for (i = 0; i < 2; i++) begin
			a = i ? TS_LAST_ADDR : TS_FIRST_ADDR;
			v = 8'($urandom) | 8'h01;
			u_host.acc(1'b1, a, v);
			rd(a, v);
			cmd(i ? CMD_BOTH_CLEAR : CMD_TS_CLEAR, i ? 3'b011 : 3'b001);
			rd(a, 8'h00);
		end
		for (i = 0; i < 8; i++) begin
			v = 8'($urandom);
			if (v == CMD_SOFT_RESET || v == CMD_TS_CLEAR || v == CMD_PRESCALER_CLEAR || v == CMD_BOTH_CLEAR)
				v = 8'h00;
			cmd(v, 3'b000);
			rd(RESET_CMD_ADDR, RESET_CMD_READBACK);
		end
		$display("test commands done");
		u_host.acc(1'b1, CTRL_ADDR, 8'hFE);
		u_host.acc(1'b1, HUNDREDTHS_ADDR, 8'h42);
		rd(HUNDREDTHS_ADDR, 8'h42);
		chk_bits({twelve_hour_mode, battery_switch_en, temp_comp_en}, 3'b110);
		cmd(CMD_SOFT_RESET, 3'b111);
		rd(HUNDREDTHS_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h19);
		chk_bits({twelve_hour_mode, battery_switch_en, clock_output_pin_en}, 3'b001);
		$display("test soft reset done");
		u_host.acc(1'b1, CTRL_ADDR, 8'h21);
		u_host.acc(1'b1, SECONDS_ADDR, 8'h59);
		u_host.acc(1'b1, HUNDREDTHS_ADDR, 8'h99);
		rd(HUNDREDTHS_ADDR, 8'h99);
		u_host.acc(1'b1, CTRL_ADDR, 8'h01);
		for (k = 0; k < 30 && minute_carry !== 1'b1; k++) @(negedge ref_clk);
		chk_bits({2'b00, minute_carry}, 3'b001);
		rd(HUNDREDTHS_ADDR, 8'h00);
		$display("test wrap done");
		mon_pins.osc_running <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk_bits({2'b00, internal_reset}, 3'b001);
		rd(SECONDS_ADDR, 8'h80);
		u_host.enter_override();
		for (k = 0; k < 40 && reset_override_mode !== 1'b1; k++) @(negedge ref_clk);
		chk_bits({1'b0, reset_override_mode, internal_reset}, 3'b010);
		u_host.acc(1'b1, CTRL_ADDR, 8'h01);
		repeat (3) @(negedge ref_clk);
		chk_bits({1'b0, reset_override_mode, internal_reset}, 3'b001);
		$display("test override done");
		wrap_up();
	end
endmodule
bind rtcrs_top rtcrs_chk u_chk (.ref_clk, .rstn, .req, .mon_pins, .rdata, .internal_reset, .reset_override_mode,
	.defaults_load, .prescaler_clear_cmd, .timestamp_clear, .clock_output_pin_en, .twelve_hour_mode,
	.battery_switch_en, .temp_comp_en);
